// *** hdl/sleep_pkg.sv ***
package sleep_pkg;

  // ==========================================================================
  // Widths
  localparam int DELAY_W  = 6;
  localparam int NUM_GLOBAL_CLOCK_NETWORK = 16;
  localparam int PAD_W    = 4;
  localparam int CNT_W    = 8;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;

  // ==========================================================================
  // Least step delays in clock cycles; smaller programmed values are raised to these.
  localparam logic [DELAY_W-1:0] IO_OFF_MIN    = 6'h01;
  localparam logic [DELAY_W-1:0] CLOCK_OFF_MIN = 6'h0b;
  localparam logic [DELAY_W-1:0] CLOCK_ON_MIN  = 6'h01;
  localparam logic [DELAY_W-1:0] IO_ON_MIN     = 6'h28;

  // ==========================================================================
  // Register offsets (byte addresses) and field positions
  localparam logic [ADDR_W-1:0] REG_DELAYS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 4'h8;

  localparam int DLY_IO_OFF_LSB    = 0;
  localparam int DLY_CLOCK_OFF_LSB = 8;
  localparam int DLY_CLOCK_ON_LSB  = 16;
  localparam int DLY_IO_ON_LSB     = 24;

  localparam int STAT_PHASE_LSB = 0;
  localparam int STAT_IOE_BIT   = 4;
  localparam int STAT_IND_BIT   = 5;
  localparam int STAT_GATE_LSB  = 16;

  localparam int CNT_VALUE_LSB = 0;
  localparam int CNT_ENTRY_LSB = 8;
  localparam int CNT_EXIT_LSB  = 16;

  // ==========================================================================
  // Clock gating steps: bits covered after each of the three steps, LSB first.
  localparam logic [1:0]          GATE_LAST_STEP = 2'h2;
  localparam logic [NUM_GLOBAL_CLOCK_NETWORK-1:0] GATE_MASK_0    = 16'h003f;
  localparam logic [NUM_GLOBAL_CLOCK_NETWORK-1:0] GATE_MASK_1    = 16'h07ff;
  localparam logic [NUM_GLOBAL_CLOCK_NETWORK-1:0] GATE_ALL       = 16'hffff;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_AWAKE      = 3'b000,
    ST_ENT_IO     = 3'b001,
    ST_ENT_CLK    = 3'b010,
    ST_ENT_GATE   = 3'b011,
    ST_SLEEP      = 3'b100,
    ST_EXT_CLK    = 3'b101,
    ST_EXT_UNGATE = 3'b110,
    ST_EXT_IO     = 3'b111
  } ctl_state_t;

  typedef enum logic [1:0] {
    PH_AWAKE    = 2'b00,
    PH_ENTERING = 2'b01,
    PH_SLEEP    = 2'b10,
    PH_EXITING  = 2'b11
  } phase_t;

  typedef struct packed {
    logic [DELAY_W-1:0] io_on;
    logic [DELAY_W-1:0] clock_on;
    logic [DELAY_W-1:0] clock_off;
    logic [DELAY_W-1:0] io_off;
  } delay_cfg_t;

  typedef struct packed {
    logic freeze;
    logic capture_entry;
    logic capture_exit;
  } user_ctl_t;

endpackage : sleep_pkg

// *** hdl/sync_two_ff.sv ***
module sync_two_ff #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         nrst_in,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second; reset low keeps a sleep request idle.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : sync_two_ff

// *** hdl/demo_counter.sv ***
module demo_counter #(
  parameter int CNT_W = sleep_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  nrst_in,
  // Control from the sequencer
  input  wire sleep_pkg::user_ctl_t  ctl_in,
  // Counter values
  output logic           [CNT_W-1:0] value_out,
  output logic           [CNT_W-1:0] entry_out,
  output logic           [CNT_W-1:0] exit_out
);

  logic [CNT_W-1:0] value_q, value_d;
  logic [CNT_W-1:0] entry_q, entry_d;
  logic [CNT_W-1:0] exit_q,  exit_d;

  // The counter also holds in the entry capture cycle, so the snapshot equals the frozen value.
  always_comb begin
    value_d = value_q;
    entry_d = entry_q;
    exit_d  = exit_q;
    if (!(ctl_in.freeze || ctl_in.capture_entry)) begin
      value_d = value_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    if (ctl_in.capture_entry) begin
      entry_d = value_q;
    end
    if (ctl_in.capture_exit) begin
      exit_d = value_q;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      value_q <= '0;
      entry_q <= '0;
      exit_q  <= '0;
    end else begin
      value_q <= value_d;
      entry_q <= entry_d;
      exit_q  <= exit_d;
    end
  end

  assign value_out = value_q;
  assign entry_out = entry_q;
  assign exit_out  = exit_q;

endmodule : demo_counter

// *** hdl/sleep_mode_power_controller.sv ***
// Summary of operation
// - A high sleep request while awake starts the entering sequence.
// - After power-down finishes, stay in sleep until the request falls.
// - A low request while asleep starts the exiting sequence.
// - After power-up finishes, return to awake and accept new requests.
// - Entering: after io_off_delay cycles, drive the I/O enable low.
// - Then after clock_off_delay, clear all sixteen clock enables LSB first within three cycles.
// - Exiting: after clock_on_delay, set all sixteen clock enables LSB first within three cycles.
// - Then after io_on_delay cycles, drive the I/O enable high again.
// - Each delay is a six-bit count; larger values lengthen it, minimums always hold.
// - The sleep indicator rises at entry and falls only after exit completes.
// - An eight-bit demo counter, counting except in the entry capture cycle, sleep and exit, is always visible on its output.
// - The counter value is captured before sleep and the counter then freezes.
// - The counter value is captured before awake and counting then resumes.
// - After a full cycle the entry and exit captures are equal.
// - Demo pads are undriven while the I/O enable is low, driven while high.
// - An active-low asynchronous reset initialises the controller.
// - The controller runs on a free-running clock in every state, sleep included.
// - After reset the I/O power-down controls sit at one, the powered state.
//
// Chosen here: strobed register access and the register offsets.
module sleep_mode_power_controller (
  // Clock and reset
  input  wire logic                                  mclk_in,
  input  wire logic                                  nrst_in,
  // Sleep request pin
  input  wire logic                                  sleep_req_in,
  // Register port
  input  wire logic        [sleep_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic        [sleep_pkg::DATA_W-1:0]   reg_wdata_in,
  input  wire logic                                  reg_wr_in,
  input  wire logic                                  reg_rd_in,
  output logic             [sleep_pkg::DATA_W-1:0]   reg_rdata_out,
  // Power controls
  output logic             [sleep_pkg::NUM_GLOBAL_CLOCK_NETWORK-1:0] clk_gate_en_out,
  output logic                                       io_enable_out,
  output logic                                       sleep_indicator_out,
  // Demo user logic
  output logic             [sleep_pkg::CNT_W-1:0]    counter_value_out,
  output logic             [sleep_pkg::CNT_W-1:0]    count_at_sleep_entry_out,
  output logic             [sleep_pkg::CNT_W-1:0]    count_at_sleep_exit_out,
  output logic             [sleep_pkg::PAD_W-1:0]    pad_data_out,
  output logic             [sleep_pkg::PAD_W-1:0]    pad_oe_out
);

  // ==========================================================================
  // Functions
  function automatic logic [sleep_pkg::DELAY_W-1:0] clamp_delay(
    input logic [sleep_pkg::DELAY_W-1:0] v,
    input logic [sleep_pkg::DELAY_W-1:0] least
  );
    clamp_delay = (v < least) ? least : v;
  endfunction : clamp_delay

  function automatic logic [sleep_pkg::NUM_GLOBAL_CLOCK_NETWORK-1:0] gate_mask(input logic [1:0] step);
    unique case (step)
      2'h0:    gate_mask = sleep_pkg::GATE_MASK_0;
      2'h1:    gate_mask = sleep_pkg::GATE_MASK_1;
      default: gate_mask = sleep_pkg::GATE_ALL;
    endcase
  endfunction : gate_mask

  function automatic sleep_pkg::phase_t phase_of(input sleep_pkg::ctl_state_t s);
    unique case (s)
      sleep_pkg::ST_AWAKE:                                              phase_of = sleep_pkg::PH_AWAKE;
      sleep_pkg::ST_ENT_IO, sleep_pkg::ST_ENT_CLK, sleep_pkg::ST_ENT_GATE: phase_of = sleep_pkg::PH_ENTERING;
      sleep_pkg::ST_SLEEP:                                              phase_of = sleep_pkg::PH_SLEEP;
      default:                                                          phase_of = sleep_pkg::PH_EXITING;
    endcase
  endfunction : phase_of

  // ==========================================================================
  // Declarations
  sleep_pkg::ctl_state_t                  state_q, state_d;
  logic [sleep_pkg::DELAY_W-1:0]          cnt_q,   cnt_d;
  logic [1:0]                             step_q,  step_d;
  logic [sleep_pkg::NUM_GLOBAL_CLOCK_NETWORK-1:0]         gate_q,  gate_d;
  logic                                   ioe_q,   ioe_d;
  logic                                   ind_q,   ind_d;
  sleep_pkg::delay_cfg_t                  dly_q,   dly_d;
  logic [sleep_pkg::DATA_W-1:0]           rdata_q, rdata_d;
  logic                                   sleep_s;
  sleep_pkg::user_ctl_t                   uctl;
  logic [sleep_pkg::DELAY_W-1:0]          t_io_off;
  logic [sleep_pkg::DELAY_W-1:0]          t_clock_off;
  logic [sleep_pkg::DELAY_W-1:0]          t_clock_on;
  logic [sleep_pkg::DELAY_W-1:0]          t_io_on;
  logic [sleep_pkg::CNT_W-1:0]            cnt_value;
  logic [sleep_pkg::CNT_W-1:0]            cnt_entry;
  logic [sleep_pkg::CNT_W-1:0]            cnt_exit;

  // ==========================================================================
  // Request synchroniser
  sync_two_ff #(
    .W (1)
  ) u_sleep_sync (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .async_in (sleep_req_in),
    .sync_out (sleep_s)
  );

  // ==========================================================================
  // Effective delays
  // Programming below a minimum would break the buffer timing, so the minimum is enforced.
  assign t_io_off    = clamp_delay(dly_q.io_off,    sleep_pkg::IO_OFF_MIN);
  assign t_clock_off = clamp_delay(dly_q.clock_off, sleep_pkg::CLOCK_OFF_MIN);
  assign t_clock_on  = clamp_delay(dly_q.clock_on,  sleep_pkg::CLOCK_ON_MIN);
  assign t_io_on     = clamp_delay(dly_q.io_on,     sleep_pkg::IO_ON_MIN);

  // ==========================================================================
  // Sequencer
  // A request level change in the middle of a sequence is only seen once it completes.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    step_d  = step_q;
    gate_d  = gate_q;
    ioe_d   = ioe_q;
    ind_d   = ind_q;
    unique case (state_q)
      sleep_pkg::ST_AWAKE: begin
        if (sleep_s) begin
          state_d = sleep_pkg::ST_ENT_IO;
          cnt_d   = '0;
          ind_d   = 1'b1;
        end
      end
      sleep_pkg::ST_ENT_IO: begin
        if (cnt_q == t_io_off - 6'h01) begin
          ioe_d   = 1'b0;
          state_d = sleep_pkg::ST_ENT_CLK;
          cnt_d   = '0;
        end else begin
          cnt_d = cnt_q + 6'h01;
        end
      end
      sleep_pkg::ST_ENT_CLK: begin
        if (cnt_q == t_clock_off - 6'h01) begin
          state_d = sleep_pkg::ST_ENT_GATE;
          step_d  = 2'h0;
        end else begin
          cnt_d = cnt_q + 6'h01;
        end
      end
      sleep_pkg::ST_ENT_GATE: begin
        gate_d = ~gate_mask(step_q);
        if (step_q == sleep_pkg::GATE_LAST_STEP) begin
          state_d = sleep_pkg::ST_SLEEP;
        end else begin
          step_d = step_q + 2'h1;
        end
      end
      sleep_pkg::ST_SLEEP: begin
        if (!sleep_s) begin
          state_d = sleep_pkg::ST_EXT_CLK;
          cnt_d   = '0;
        end
      end
      sleep_pkg::ST_EXT_CLK: begin
        if (cnt_q == t_clock_on - 6'h01) begin
          state_d = sleep_pkg::ST_EXT_UNGATE;
          step_d  = 2'h0;
        end else begin
          cnt_d = cnt_q + 6'h01;
        end
      end
      sleep_pkg::ST_EXT_UNGATE: begin
        gate_d = gate_mask(step_q);
        if (step_q == sleep_pkg::GATE_LAST_STEP) begin
          state_d = sleep_pkg::ST_EXT_IO;
          cnt_d   = '0;
        end else begin
          step_d = step_q + 2'h1;
        end
      end
      sleep_pkg::ST_EXT_IO: begin
        if (cnt_q == t_io_on - 6'h01) begin
          ioe_d   = 1'b1;
          ind_d   = 1'b0;
          state_d = sleep_pkg::ST_AWAKE;
        end else begin
          cnt_d = cnt_q + 6'h01;
        end
      end
    endcase
  end

  // The oscillator never stops, so this state advances through sleep as well.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= sleep_pkg::ST_AWAKE;
      cnt_q   <= '0;
      step_q  <= 2'h0;
      gate_q  <= sleep_pkg::GATE_ALL;
      ioe_q   <= 1'b1;
      ind_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      step_q  <= step_d;
      gate_q  <= gate_d;
      ioe_q   <= ioe_d;
      ind_q   <= ind_d;
    end
  end

  // ==========================================================================
  // Demo user logic
  always_comb begin
    uctl.freeze        = (state_q == sleep_pkg::ST_SLEEP) || (phase_of(state_q) == sleep_pkg::PH_EXITING);
    uctl.capture_entry = (state_q == sleep_pkg::ST_ENT_GATE) && (step_q == sleep_pkg::GATE_LAST_STEP);
    uctl.capture_exit  = (state_q == sleep_pkg::ST_EXT_IO) && (cnt_q == t_io_on - 6'h01);
  end

  demo_counter #(
    .CNT_W (sleep_pkg::CNT_W)
  ) u_demo (
    .mclk_in   (mclk_in),
    .nrst_in   (nrst_in),
    .ctl_in    (uctl),
    .value_out (cnt_value),
    .entry_out (cnt_entry),
    .exit_out  (cnt_exit)
  );

  // ==========================================================================
  // Register port
  always_comb begin
    dly_d   = dly_q;
    rdata_d = '0;
    if (reg_wr_in && (reg_addr_in == sleep_pkg::REG_DELAYS)) begin
      dly_d.io_off    = reg_wdata_in[sleep_pkg::DLY_IO_OFF_LSB    +: sleep_pkg::DELAY_W];
      dly_d.clock_off = reg_wdata_in[sleep_pkg::DLY_CLOCK_OFF_LSB +: sleep_pkg::DELAY_W];
      dly_d.clock_on  = reg_wdata_in[sleep_pkg::DLY_CLOCK_ON_LSB  +: sleep_pkg::DELAY_W];
      dly_d.io_on     = reg_wdata_in[sleep_pkg::DLY_IO_ON_LSB     +: sleep_pkg::DELAY_W];
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        sleep_pkg::REG_DELAYS: begin
          rdata_d[sleep_pkg::DLY_IO_OFF_LSB    +: sleep_pkg::DELAY_W] = dly_q.io_off;
          rdata_d[sleep_pkg::DLY_CLOCK_OFF_LSB +: sleep_pkg::DELAY_W] = dly_q.clock_off;
          rdata_d[sleep_pkg::DLY_CLOCK_ON_LSB  +: sleep_pkg::DELAY_W] = dly_q.clock_on;
          rdata_d[sleep_pkg::DLY_IO_ON_LSB     +: sleep_pkg::DELAY_W] = dly_q.io_on;
        end
        sleep_pkg::REG_STATUS: begin
          rdata_d[sleep_pkg::STAT_PHASE_LSB +: 2]                  = phase_of(state_q);
          rdata_d[sleep_pkg::STAT_IOE_BIT]                         = ioe_q;
          rdata_d[sleep_pkg::STAT_IND_BIT]                         = ind_q;
          rdata_d[sleep_pkg::STAT_GATE_LSB +: sleep_pkg::NUM_GLOBAL_CLOCK_NETWORK] = gate_q;
        end
        sleep_pkg::REG_COUNT: begin
          rdata_d[sleep_pkg::CNT_VALUE_LSB +: sleep_pkg::CNT_W] = cnt_value;
          rdata_d[sleep_pkg::CNT_ENTRY_LSB +: sleep_pkg::CNT_W] = cnt_entry;
          rdata_d[sleep_pkg::CNT_EXIT_LSB  +: sleep_pkg::CNT_W] = cnt_exit;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dly_q   <= '{io_on: sleep_pkg::IO_ON_MIN, clock_on: sleep_pkg::CLOCK_ON_MIN,
                   clock_off: sleep_pkg::CLOCK_OFF_MIN, io_off: sleep_pkg::IO_OFF_MIN};
      rdata_q <= '0;
    end else begin
      dly_q   <= dly_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_out            = rdata_q;
  assign clk_gate_en_out          = gate_q;
  assign io_enable_out            = ioe_q;
  assign sleep_indicator_out      = ind_q;
  assign counter_value_out        = cnt_value;
  assign count_at_sleep_entry_out = cnt_entry;
  assign count_at_sleep_exit_out  = cnt_exit;
  assign pad_data_out             = cnt_value[sleep_pkg::PAD_W-1:0];
  assign pad_oe_out               = {sleep_pkg::PAD_W{ioe_q}};

  // ==========================================================================
  // Assertions
  property p_enter;
    @(posedge mclk_in) disable iff (!nrst_in)
      (state_q == sleep_pkg::ST_AWAKE && sleep_s) |=> (state_q == sleep_pkg::ST_ENT_IO) && ind_q;
  endproperty
  a_enter: assert property (p_enter) else $error("sleep request not followed by entry");

  property p_ioe_off;
    @(posedge mclk_in) disable iff (!nrst_in)
      $fell(ioe_q) |-> $past(state_q) == sleep_pkg::ST_ENT_IO && $past(cnt_q) == $past(t_io_off) - 6'h01;
  endproperty
  a_ioe_off: assert property (p_ioe_off) else $error("I/O enable fell at the wrong moment");

  property p_gate_off;
    @(posedge mclk_in) disable iff (!nrst_in)
      $rose(state_q == sleep_pkg::ST_ENT_GATE) |-> ##3 (gate_q == '0) && (state_q == sleep_pkg::ST_SLEEP);
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("clock enables not cleared in three cycles");

  property p_gate_order;
    @(posedge mclk_in) disable iff (!nrst_in)
      (state_q == sleep_pkg::ST_ENT_GATE || state_q == sleep_pkg::ST_EXT_UNGATE)
        |=> ((~gate_q & (~gate_q + 16'h0001)) == '0) || ((gate_q & (gate_q + 16'h0001)) == '0);
  endproperty
  a_gate_order: assert property (p_gate_order) else $error("clock enables changed out of order");

  property p_gate_on;
    @(posedge mclk_in) disable iff (!nrst_in)
      $rose(state_q == sleep_pkg::ST_EXT_UNGATE) |-> ##3 (gate_q == sleep_pkg::GATE_ALL)
        && (state_q == sleep_pkg::ST_EXT_IO);
  endproperty
  a_gate_on: assert property (p_gate_on) else $error("clock enables not set in three cycles");

  property p_ioe_on;
    @(posedge mclk_in) disable iff (!nrst_in)
      $rose(ioe_q) |-> $past(gate_q) == sleep_pkg::GATE_ALL && state_q == sleep_pkg::ST_AWAKE && !ind_q;
  endproperty
  a_ioe_on: assert property (p_ioe_on) else $error("I/O enable rose before clocks restored");

  property p_sleep_hold;
    @(posedge mclk_in) disable iff (!nrst_in)
      (state_q == sleep_pkg::ST_SLEEP) |-> !ioe_q && gate_q == '0 && ind_q;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep state with power still on");

  property p_indicator;
    @(posedge mclk_in) disable iff (!nrst_in)
      ind_q == (state_q != sleep_pkg::ST_AWAKE);
  endproperty
  a_indicator: assert property (p_indicator) else $error("sleep indicator disagrees with state");

  property p_pads;
    @(posedge mclk_in) disable iff (!nrst_in)
      !io_enable_out |-> pad_oe_out == '0;
  endproperty
  a_pads: assert property (p_pads) else $error("pads driven while I/O disabled");

  property p_min_delay;
    @(posedge mclk_in) disable iff (!nrst_in)
      ($rose(state_q == sleep_pkg::ST_ENT_GATE) |-> $past(cnt_q) >= sleep_pkg::CLOCK_OFF_MIN - 6'h01)
        and ($rose(ioe_q) |-> $past(cnt_q) >= sleep_pkg::IO_ON_MIN - 6'h01);
  endproperty
  a_min_delay: assert property (p_min_delay) else $error("delay below its least value");

  property p_counts_match;
    @(posedge mclk_in) disable iff (!nrst_in)
      uctl.capture_exit |=> cnt_entry == cnt_exit && state_q == sleep_pkg::ST_AWAKE;
  endproperty
  a_counts_match: assert property (p_counts_match) else $error("counter captures differ");

endmodule : sleep_mode_power_controller

// *** sim/far_side_model.sv ***
// ==========================================================================
// Clock control blocks and pad buffers seen from the far side of the block.
module far_side_model (
  // Clock
  input  wire logic                          mclk_in,
  // Controls from the block
  input  wire logic [sleep_pkg::NUM_GLOBAL_CLOCK_NETWORK-1:0] gate_en_in,
  input  wire logic [sleep_pkg::PAD_W-1:0]    pad_data_in,
  input  wire logic [sleep_pkg::PAD_W-1:0]    pad_oe_in,
  // Observed pad level and clock activity
  output logic      [sleep_pkg::PAD_W-1:0]    pad_level_out,
  output logic      [31:0]                    edges_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] edges_q = 32'h0;
  // Only the top network is counted; it is the last one gated off, so it proves the whole set stopped.
  always @(posedge mclk_in) begin
    if (gate_en_in[sleep_pkg::NUM_GLOBAL_CLOCK_NETWORK-1]) edges_q <= edges_q + 32'h1;
  end
  assign edges_out = edges_q;
  // A released pad floats to the weak pull-up, so stale data never looks driven.
  assign pad_level_out = (pad_oe_in & pad_data_in) | ~pad_oe_in;
endmodule : far_side_model

// *** sim/sleep_mode_power_controller_bench.sv ***
module sleep_mode_power_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 5000;
  // ==========================================================================
  // Signals
  logic        mclk_in, nrst_in, sleep_req_in, reg_wr_in, reg_rd_in, rd_d;
  logic [3:0]  reg_addr_in, pad_data_out, pad_oe_out, pad_level;
  logic [31:0] reg_wdata_in, reg_rdata_out, edges;
  logic [15:0] clk_gate_en_out;
  logic        io_enable_out, sleep_indicator_out;
  logic [7:0]  counter_value_out, count_at_sleep_entry_out, count_at_sleep_exit_out, cnt0;
  logic [31:0] exp_q[$];
  int          n_mismatch, total_checks, cyc, seed;

  sleep_mode_power_controller sleep_mode_power_controller_i (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .sleep_req_in(sleep_req_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .clk_gate_en_out(clk_gate_en_out), .io_enable_out(io_enable_out),
    .sleep_indicator_out(sleep_indicator_out), .counter_value_out(counter_value_out),
    .count_at_sleep_entry_out(count_at_sleep_entry_out), .count_at_sleep_exit_out(count_at_sleep_exit_out),
    .pad_data_out(pad_data_out), .pad_oe_out(pad_oe_out));
  far_side_model far_side_model_i (.mclk_in(mclk_in), .gate_en_in(clk_gate_en_out), .pad_data_in(pad_data_out),
    .pad_oe_in(pad_oe_out), .pad_level_out(pad_level), .edges_out(edges));

  // ==========================================================================
  // Checking and reporting
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    rd_d <= reg_rd_in;
    if (cyc == LIMIT) begin
      n_mismatch++;
      final_report();
    end
  end
  // Read data stands only in the cycle after the strobe, so it is taken mid-cycle.
  always @(negedge mclk_in) begin
    if (rd_d) check("reg_rdata", reg_rdata_out, exp_q.pop_front());
  end

  // ==========================================================================
  // Drivers
  // A strobe stays up across back-to-back transfers; bus_idle lowers both afterwards.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_rd_in <= 1'b0;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_wr_in <= 1'b0;
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk_in);
  endtask : rd
  task automatic bus_idle();
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
  endtask : bus_idle
  task automatic wait_for(input int which, input logic [15:0] v);
    logic [15:0] s;
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
      s = (which == 0) ? 16'(sleep_indicator_out) : (which == 1) ? 16'(io_enable_out) : clk_gate_en_out;
    end while (s !== v && n < 400);
  endtask : wait_for
  task automatic step(input string what, input logic [15:0] v);
    @(posedge mclk_in);
    #1;
    check(what, 32'(clk_gate_en_out), 32'(v));
  endtask : step

  // ==========================================================================
  // One full sleep and wake cycle with the given raw delay word.
  task automatic sleep_cycle(input logic [31:0] raw);
    logic [5:0] t1, t2, t3, t4;
    logic [7:0] frz;
    logic [31:0] e0;
    int c0;
    t1 = (raw[5:0] < sleep_pkg::IO_OFF_MIN) ? sleep_pkg::IO_OFF_MIN : raw[5:0];
    t2 = (raw[13:8] < sleep_pkg::CLOCK_OFF_MIN) ? sleep_pkg::CLOCK_OFF_MIN : raw[13:8];
    t3 = (raw[21:16] < sleep_pkg::CLOCK_ON_MIN) ? sleep_pkg::CLOCK_ON_MIN : raw[21:16];
    t4 = (raw[29:24] < sleep_pkg::IO_ON_MIN) ? sleep_pkg::IO_ON_MIN : raw[29:24];
    wr(sleep_pkg::REG_DELAYS, raw);
    rd(sleep_pkg::REG_DELAYS, raw);
    bus_idle();
    sleep_req_in <= 1'b1;
    wait_for(0, 16'h1);
    c0 = cyc;
    wait_for(1, 16'h0);
    check("io_off_delay", 32'(cyc - c0), 32'(t1));
    check("pads_off", {pad_oe_out, pad_level, sleep_indicator_out}, 9'h1f);
    c0 = cyc;
    // A short drop of the request while entering must not turn the sequence round.
    sleep_req_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    sleep_req_in <= 1'b1;
    wait_for(2, 16'hffc0);
    // The first gating step follows the wait by one cycle in the gating state.
    check("clock_off_delay", 32'(cyc - c0), 32'(t2) + 32'h1);
    step("gate_off_1", 16'hf800);
    step("gate_off_2", 16'h0000);
    frz = counter_value_out;
    e0 = edges;
    check("entry_capture", 32'(count_at_sleep_entry_out), 32'(frz));
    repeat (20) @(posedge mclk_in);
    #1;
    check("frozen_count", 32'(counter_value_out), 32'(frz));
    check("gated_clock", edges, e0);
    rd(sleep_pkg::REG_STATUS, 32'h0000_0022);
    bus_idle();
    sleep_req_in <= 1'b0;
    #1;
    c0 = cyc;
    wait_for(2, 16'h003f);
    // Two synchroniser stages, the deciding edge, the wait, then the first step.
    check("clock_on_delay", 32'(cyc - c0), 32'(t3) + 32'h4);
    step("gate_on_1", 16'h07ff);
    step("gate_on_2", 16'hffff);
    c0 = cyc;
    wait_for(1, 16'h1);
    check("io_on_delay", 32'(cyc - c0), 32'(t4));
    check("indicator_low", 32'(sleep_indicator_out), 32'h0);
    check("exit_capture", 32'(count_at_sleep_exit_out), 32'(count_at_sleep_entry_out));
    repeat (4) @(posedge mclk_in);
    #1;
    check("resumed", 32'(counter_value_out != frz && edges != e0), 32'h1);
    check("pads_on", {pad_oe_out, pad_level}, {4'hf, pad_data_out});
    $display("test sleep cycle %h done", raw);
  endtask : sleep_cycle

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h9e74;
    {nrst_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    sleep_req_in = 1'b0;
    repeat (16) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    check("reset_out", {clk_gate_en_out, io_enable_out, sleep_indicator_out, pad_oe_out}, 22'h3fffef);
    cnt0 = counter_value_out;
    repeat (10) @(posedge mclk_in);
    #1;
    check("free_run", 32'(counter_value_out), 32'(cnt0 + 8'h0a));
    wr(sleep_pkg::REG_STATUS, 32'h0);
    rd(sleep_pkg::REG_STATUS, 32'hffff_0010);
    rd(sleep_pkg::REG_DELAYS, 32'h2801_0b01);
    wr(4'hc, 32'hffff_ffff);
    rd(4'hc, 32'h0);
    $display("test registers done");
    sleep_cycle(32'h2801_0b01);
    sleep_cycle(32'h0);
    sleep_cycle(32'($random(seed)) & 32'h3f3f_3f3f);
    final_report();
  end
endmodule : sleep_mode_power_controller_bench
